// ---- core/foc_pkg.sv ----
// shared constants and register layouts of the flash operation control block
package foc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] OFS_MCR  = 8'h00;
  localparam logic [7:0] OFS_UT0  = 8'h04;
  localparam logic [7:0] OFS_PFCR = 8'h08;
  localparam logic [7:0] OFS_STS  = 8'h0C;
  localparam logic [7:0] OFS_CLR  = 8'h10;
  localparam logic [7:0] OFS_EN   = 8'h14;

  // read-only bit positions and register field widths
  localparam int OP_DONE_BIT  = 8;
  localparam int RCV_BUSY_BIT = 9;
  localparam int CHK_DONE_BIT = 8;
  localparam int CTL_W        = 5;
  localparam int UT_W         = 4;
  localparam int PF_W         = 6;
  localparam int EV_W         = 3;

  ////////////////////////////////////////////////////////////////////////////
  // register layouts (first field is the most significant)
  typedef struct packed {
    logic low_power;
    logic erase_sel;
    logic erase_suspend;
    logic prog_suspend;
    logic high_voltage_enable;
  } foc_mcr_t;

  typedef struct packed {
    logic integrity_breakpoint_bit;
    logic margin_mode;
    logic integrity_check_suspend;
    logic integrity_check_enable;
  } foc_ut0_t;

  typedef struct packed {
    logic [1:0] address_pipeline_ctrl;
    logic [3:0] read_wait_states;
  } foc_pfcr_t;

  // sticky events: recovery finished, check done set, operation done set
  typedef struct packed {
    logic rcv_done;
    logic chk_done;
    logic op_done;
  } foc_ev_t;

  localparam foc_mcr_t  MCR_RST  = 5'h00;
  localparam foc_ut0_t  UT0_RST  = 4'h0;
  // 50 MHz platform clock sits in the 33..100 MHz band
  localparam foc_pfcr_t PFCR_RST = 6'h12;
  localparam foc_ev_t   EV_RST   = 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // timing, times in ns, counts in 20 ns cycles
  localparam int CLK_NS          = 20;
  localparam int T_PSUS_TYP_NS   = 9400;
  localparam int T_ESUS_MAX_NS   = 20800;
  localparam int T_DONES_TYP_NS  = 16000;
  localparam int T_DRCV_MIN_NS   = 16000;
  localparam int T_AISTOP_MAX_NS = 80;
  localparam int T_MRSTOP_MIN_NS = 10360;

  localparam logic [15:0] PSUS_CYC   = 16'(T_PSUS_TYP_NS / CLK_NS + 4);
  localparam logic [15:0] ESUS_CYC   = 16'(T_ESUS_MAX_NS / CLK_NS + 4);
  localparam logic [15:0] DONES_CYC  = 16'(T_DONES_TYP_NS / CLK_NS + 4);
  localparam logic [15:0] RCV_CYC    = 16'((T_DRCV_MIN_NS + CLK_NS - 1) / CLK_NS + 7);
  localparam logic [15:0] AISTOP_CYC = 16'(T_AISTOP_MAX_NS / CLK_NS + 15);
  localparam logic [15:0] MRSTOP_CYC = 16'((T_MRSTOP_MIN_NS + CLK_NS - 1) / CLK_NS + 4);

  // read latency: miss = wait states + base, hit = one period
  localparam logic [4:0] MISS_BASE = 5'h03;
  localparam logic [4:0] HIT_LAT   = 5'h01;

  ////////////////////////////////////////////////////////////////////////////
  // state machines
  typedef enum logic [4:0] {
    OP_IDLE  = 5'h01,
    OP_RUN   = 5'h02,
    OP_SUSW  = 5'h04,
    OP_SUSP  = 5'h08,
    OP_ABORT = 5'h10
  } foc_op_st_t;

  typedef enum logic [4:0] {
    CK_IDLE = 5'h01,
    CK_RUN  = 5'h02,
    CK_SUSW = 5'h04,
    CK_ABRT = 5'h08,
    CK_HELD = 5'h10
  } foc_ck_st_t;

endpackage

// ---- core/foc_timer.sv ----
// down-counting delay timer with a one-cycle expiry pulse
`timescale 1ns/1ns
module foc_timer (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // control
  input  wire logic        load,
  input  wire logic [15:0] load_cnt,
  input  wire logic        cancel,
  // status
  output logic             expire,
  output logic             busy
);

  logic [15:0] cnt_q;

  // expire rises load_cnt edges after the loading edge
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_q  <= 16'h0000;
      busy   <= 1'b0;
      expire <= 1'b0;
    end else begin
      expire <= busy && cnt_q == 16'h0001 && !load && !cancel;
      if (load) begin
        cnt_q <= load_cnt;
        busy  <= 1'b1;
      end else if (cancel) begin
        busy <= 1'b0;
      end else if (busy) begin
        cnt_q <= cnt_q - 16'h0001;
        if (cnt_q == 16'h0001) begin
          busy <= 1'b0;
        end
      end
    end
  end

endmodule

// ---- core/foc_ctrl.sv ----
// flash program, erase and integrity-check sequencer with wishbone registers
//
// Local design decisions: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ns

// Contract
// [RQ1] after program suspend is requested the done flag rises within 11.5 us plus four clocks.
// [RQ2] after erase suspend is requested the done flag rises within 20.8 us plus four clocks.
// [RQ3] clearing a suspend bit while high voltage is enabled drops done within 100 ns.
// [RQ4] a rising high voltage enable starts an operation and clears done within 5 ns.
// [RQ5] a falling high voltage enable aborts and sets done after 16 to 20.8 us plus four clocks.
// [RQ6] leaving low power needs 16 to 45 us plus seven clocks before the flash is used; checks and a start in the same write as the exit do not wait.
// [RQ7] a rising check enable starts a check and clears the check done flag within 5 ns.
// [RQ8] resuming a check by clearing suspend or breakpoint clears check done within 5 ns.
// [RQ9] dropping check enable during an integrity check sets check done within 80 ns plus 15 clocks.
// [RQ10] suspending an integrity check sets check done within 80 ns plus 15 clocks.
// [RQ11] dropping check enable in a margin read sets check done 10.36 to 20.42 us plus four clocks.
// [RQ12] suspending a margin read sets check done 10.36 to 20.42 us plus four clocks.
// [RQ13] software picks wait states and pipeline 0/0, 2/1 or 3/1 for the three clock bands.
// [RQ14] a read miss takes 3, 5 or 6 clocks for those settings and a hit takes one clock.
// [RQ15] both done flags stay readable and hold until a start, resume or abort changes them.
module foc_ctrl #(
  parameter logic [15:0] PGM_CYC = 16'd5000,
  parameter logic [15:0] ERS_CYC = 16'd50000,
  parameter logic [15:0] CHK_CYC = 16'd2048
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // interrupt
  output logic             irq_o,
  // flash read port
  input  wire logic        rd_req,
  input  wire logic        rd_hit,
  output logic             rd_ack
);

  ////////////////////////////////////////////////////////////////////////////
  // register state and bus decode
  foc_pkg::foc_mcr_t   mcr_q;
  foc_pkg::foc_ut0_t   ut0_q;
  foc_pkg::foc_pfcr_t  pfcr_q;
  foc_pkg::foc_ev_t    sts_q;
  foc_pkg::foc_ev_t    en_q;
  foc_pkg::foc_ev_t    ev;
  foc_pkg::foc_mcr_t   nm;
  foc_pkg::foc_ut0_t   nu;
  foc_pkg::foc_op_st_t op_st_q;
  foc_pkg::foc_op_st_t op_st_d;
  foc_pkg::foc_ck_st_t ck_st_q;
  foc_pkg::foc_ck_st_t ck_st_d;
  logic                op_done_q;
  logic                chk_done_q;
  logic                acc;
  logic                wr;
  logic                wr_mcr;
  logic                wr_ut0;
  logic                op_load;
  logic [15:0]         op_val;
  logic                op_exp;
  logic                op_busy;
  logic                op_set;
  logic                op_clr;
  logic                ck_load;
  logic [15:0]         ck_val;
  logic                ck_exp;
  logic                ck_busy;
  logic                ck_set;
  logic                ck_clr;
  logic                rcv_exp;
  logic                rcv_busy;
  logic                lp_fall;
  logic                rd_busy_q;
  logic [4:0]          rd_cnt_q;
  logic [4:0]          rd_lat;
  logic                rd_take;

  assign acc    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr     = acc && wb_we_i && wb_sel_i[0];
  assign wr_mcr = wr && wb_adr_i == foc_pkg::OFS_MCR;
  assign wr_ut0 = wr && wb_adr_i == foc_pkg::OFS_UT0;
  assign nm     = foc_pkg::foc_mcr_t'(wb_dat_i[foc_pkg::CTL_W-1:0]);
  assign nu     = foc_pkg::foc_ut0_t'(wb_dat_i[foc_pkg::UT_W-1:0]);

  // single-cycle answer, ack drops the cycle after it was given
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= acc;
      if (acc) begin
        wb_dat_o <= 32'h0000_0000;
        case (wb_adr_i)
          foc_pkg::OFS_MCR: begin
            wb_dat_o[foc_pkg::CTL_W-1:0]     <= mcr_q;
            wb_dat_o[foc_pkg::OP_DONE_BIT]   <= op_done_q; // RQ15
            wb_dat_o[foc_pkg::RCV_BUSY_BIT]  <= rcv_busy; // RQ6
          end
          foc_pkg::OFS_UT0: begin
            wb_dat_o[foc_pkg::UT_W-1:0]      <= ut0_q;
            wb_dat_o[foc_pkg::CHK_DONE_BIT]  <= chk_done_q; // RQ15
          end
          foc_pkg::OFS_PFCR: wb_dat_o[foc_pkg::PF_W-1:0] <= pfcr_q;
          foc_pkg::OFS_STS:  wb_dat_o[foc_pkg::EV_W-1:0] <= sts_q;
          foc_pkg::OFS_EN:   wb_dat_o[foc_pkg::EV_W-1:0] <= en_q;
          default:           wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // software-written control registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mcr_q  <= foc_pkg::MCR_RST;
      ut0_q  <= foc_pkg::UT0_RST;
      pfcr_q <= foc_pkg::PFCR_RST;
      en_q   <= foc_pkg::EV_RST;
    end else if (wr) begin
      case (wb_adr_i)
        foc_pkg::OFS_MCR:  mcr_q  <= nm;
        foc_pkg::OFS_UT0:  ut0_q  <= nu;
        foc_pkg::OFS_PFCR: pfcr_q <= foc_pkg::foc_pfcr_t'(wb_dat_i[foc_pkg::PF_W-1:0]); // RQ13
        foc_pkg::OFS_EN:   en_q   <= foc_pkg::foc_ev_t'(wb_dat_i[foc_pkg::EV_W-1:0]);
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // program / erase sequencer
  foc_timer u_op_tmr (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .load     (op_load),
    .load_cnt (op_val),
    .cancel   (1'b0),
    .expire   (op_exp),
    .busy     (op_busy)
  );

  always_comb begin
    op_st_d = op_st_q;
    op_load = 1'b0;
    op_val  = 16'h0000;
    op_set  = 1'b0;
    op_clr  = 1'b0;
    case (op_st_q)
      foc_pkg::OP_IDLE: begin
        // no start if the written low power bit is set or a recovery is already running
        if (wr_mcr && nm.high_voltage_enable && !mcr_q.high_voltage_enable
            && !nm.low_power && !rcv_busy) begin
          op_clr  = 1'b1; // RQ4
          op_load = 1'b1;
          op_val  = (nm.erase_sel ? ERS_CYC : PGM_CYC) - 16'h0001;
          op_st_d = foc_pkg::OP_RUN;
        end
      end
      foc_pkg::OP_RUN: begin
        if (wr_mcr && !nm.high_voltage_enable) begin
          op_load = 1'b1;
          op_val  = foc_pkg::DONES_CYC - 16'h0001; // RQ5
          op_st_d = foc_pkg::OP_ABORT;
        end else if (wr_mcr && nm.erase_suspend && !mcr_q.erase_suspend) begin
          op_load = 1'b1;
          op_val  = foc_pkg::ESUS_CYC - 16'h0001; // RQ2
          op_st_d = foc_pkg::OP_SUSW;
        end else if (wr_mcr && nm.prog_suspend && !mcr_q.prog_suspend) begin
          op_load = 1'b1;
          op_val  = foc_pkg::PSUS_CYC - 16'h0001; // RQ1
          op_st_d = foc_pkg::OP_SUSW;
        end else if (op_exp) begin
          op_set  = 1'b1;
          op_st_d = foc_pkg::OP_IDLE;
        end
      end
      foc_pkg::OP_SUSW, foc_pkg::OP_SUSP: begin
        if (wr_mcr && !nm.high_voltage_enable) begin
          op_load = 1'b1;
          op_val  = foc_pkg::DONES_CYC - 16'h0001; // RQ5
          op_st_d = foc_pkg::OP_ABORT;
        end else if (op_st_q == foc_pkg::OP_SUSW && op_exp) begin
          op_set  = 1'b1; // RQ1 RQ2
          op_st_d = foc_pkg::OP_SUSP;
        end else if (op_st_q == foc_pkg::OP_SUSP && wr_mcr
                     && !nm.prog_suspend && !nm.erase_suspend) begin
          // resume restarts the whole operation time, not the remainder
          op_clr  = 1'b1; // RQ3
          op_load = 1'b1;
          op_val  = (mcr_q.erase_sel ? ERS_CYC : PGM_CYC) - 16'h0001;
          op_st_d = foc_pkg::OP_RUN;
        end
      end
      foc_pkg::OP_ABORT: begin
        if (op_exp) begin
          op_set  = 1'b1; // RQ5
          op_st_d = foc_pkg::OP_IDLE;
        end
      end
      default: op_st_d = foc_pkg::OP_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      op_st_q   <= foc_pkg::OP_IDLE;
      op_done_q <= 1'b1;
    end else begin
      op_st_q <= op_st_d;
      if (op_set) begin
        op_done_q <= 1'b1;
      end else if (op_clr) begin
        op_done_q <= 1'b0; // RQ15
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // margin read / array integrity sequencer
  foc_timer u_ck_tmr (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .load     (ck_load),
    .load_cnt (ck_val),
    .cancel   (1'b0),
    .expire   (ck_exp),
    .busy     (ck_busy)
  );

  always_comb begin
    ck_st_d = ck_st_q;
    ck_load = 1'b0;
    ck_val  = (ut0_q.margin_mode ? foc_pkg::MRSTOP_CYC : foc_pkg::AISTOP_CYC) - 16'h0001;
    ck_set  = 1'b0;
    ck_clr  = 1'b0;
    case (ck_st_q)
      foc_pkg::CK_IDLE: begin
        if (wr_ut0 && nu.integrity_check_enable && !ut0_q.integrity_check_enable) begin
          ck_clr  = 1'b1; // RQ7
          ck_load = 1'b1;
          ck_val  = CHK_CYC - 16'h0001;
          ck_st_d = foc_pkg::CK_RUN;
        end
      end
      foc_pkg::CK_RUN: begin
        if (wr_ut0 && !nu.integrity_check_enable) begin
          ck_load = 1'b1; // RQ9 RQ11
          ck_st_d = foc_pkg::CK_ABRT;
        end else if (wr_ut0 && nu.integrity_check_suspend) begin
          ck_load = 1'b1; // RQ10 RQ12
          ck_st_d = foc_pkg::CK_SUSW;
        end else if (ck_exp) begin
          ck_set  = 1'b1;
          ck_st_d = ut0_q.integrity_breakpoint_bit ? foc_pkg::CK_HELD : foc_pkg::CK_IDLE;
        end
      end
      foc_pkg::CK_SUSW, foc_pkg::CK_ABRT: begin
        if (ck_exp) begin
          ck_set  = 1'b1; // RQ9 RQ10 RQ11 RQ12
          ck_st_d = ck_st_q == foc_pkg::CK_SUSW ? foc_pkg::CK_HELD : foc_pkg::CK_IDLE;
        end
      end
      foc_pkg::CK_HELD: begin
        if (wr_ut0 && !nu.integrity_check_enable) begin
          ck_st_d = foc_pkg::CK_IDLE;
        end else if (wr_ut0 && !nu.integrity_check_suspend
                     && (ut0_q.integrity_check_suspend
                         || (ut0_q.integrity_breakpoint_bit
                             && !nu.integrity_breakpoint_bit))) begin
          ck_clr  = 1'b1; // RQ8
          ck_load = 1'b1;
          ck_val  = CHK_CYC - 16'h0001;
          ck_st_d = foc_pkg::CK_RUN;
        end
      end
      default: ck_st_d = foc_pkg::CK_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ck_st_q    <= foc_pkg::CK_IDLE;
      chk_done_q <= 1'b1;
    end else begin
      ck_st_q <= ck_st_d;
      if (ck_set) begin
        chk_done_q <= 1'b1;
      end else if (ck_clr) begin
        chk_done_q <= 1'b0; // RQ15
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // low-power exit recovery
  assign lp_fall = wr_mcr && mcr_q.low_power && !nm.low_power;

  foc_timer u_rcv_tmr (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .load     (lp_fall),
    .load_cnt (foc_pkg::RCV_CYC), // RQ6
    .cancel   (1'b0),
    .expire   (rcv_exp),
    .busy     (rcv_busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // flash read latency
  assign rd_lat  = rd_hit ? foc_pkg::HIT_LAT
                          : foc_pkg::MISS_BASE + {1'b0, pfcr_q.read_wait_states}; // RQ14
  assign rd_take = rd_req && !rd_busy_q && !rd_ack && !mcr_q.low_power && !rcv_busy; // RQ6

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_busy_q <= 1'b0;
      rd_cnt_q  <= 5'h00;
      rd_ack    <= 1'b0;
    end else begin
      rd_ack <= (rd_take && rd_lat == foc_pkg::HIT_LAT)
                || (rd_busy_q && rd_cnt_q == 5'h01); // RQ14
      if (rd_take && rd_lat != foc_pkg::HIT_LAT) begin
        rd_busy_q <= 1'b1;
        rd_cnt_q  <= rd_lat - 5'h01;
      end else if (rd_busy_q) begin
        rd_cnt_q <= rd_cnt_q - 5'h01;
        if (rd_cnt_q == 5'h01) begin
          rd_busy_q <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status, set wins over a same-cycle clear
  assign ev = '{rcv_done: rcv_exp, chk_done: ck_set, op_done: op_set};

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sts_q <= foc_pkg::EV_RST;
      irq_o <= 1'b0;
    end else begin
      if (wr && wb_adr_i == foc_pkg::OFS_CLR) begin
        sts_q <= (sts_q & ~foc_pkg::foc_ev_t'(wb_dat_i[foc_pkg::EV_W-1:0])) | ev;
      end else begin
        sts_q <= sts_q | ev;
      end
      irq_o <= |(sts_q & en_q);
    end
  end

endmodule

// ---- test/foc_ctrl_properties.sv ----
// port-level assertions for the flash operation control block
`timescale 1ns/1ns
module foc_ctrl_properties (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        rst,
  // wishbone
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // interrupt and read port
  input wire logic        irq_o,
  input wire logic        rd_req,
  input wire logic        rd_hit,
  input wire logic        rd_ack
);
  logic [3:0] ws_q;
  logic [2:0] en_q;
  logic [4:0] lat_q;
  logic       hit_q;
  logic       wr_take;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  assign wr_take = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0];

  ////////////////////////////////////////////////////////////////////////////
  // shadow of the wait-state and enable registers
  always_ff @(posedge clk_sys) begin
    if (rst) ws_q <= foc_pkg::PFCR_RST.read_wait_states;
    else if (wr_take && wb_adr_i == foc_pkg::OFS_PFCR) ws_q <= wb_dat_i[3:0];
  end
  always_ff @(posedge clk_sys) begin
    if (rst) en_q <= 3'h0;
    else if (wr_take && wb_adr_i == foc_pkg::OFS_EN) en_q <= wb_dat_i[2:0];
  end
  // cycles a read request has waited
  always_ff @(posedge clk_sys) begin
    if (rst || !rd_req) lat_q <= 5'h00;
    else if (!rd_ack) lat_q <= lat_q + 5'h01;
  end
  always_ff @(posedge clk_sys) begin
    if (rd_req && lat_q == 5'h00) hit_q <= rd_hit;
  end

  ////////////////////////////////////////////////////////////////////////////
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered next cycle");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack longer than one cycle");
  a_dat_steady: assert property (!wb_ack_o && !$past(rst) |-> $stable(wb_dat_o))
    else $error("read data changed without an access");
  a_rdack_pulse: assert property (rd_ack |=> !rd_ack)
    else $error("read ack longer than one cycle");
  a_rdack_cause: assert property (rd_ack |-> rd_req && lat_q != 5'h00)
    else $error("read ack without a pending request");
  a_hit_lat: assert property (rd_ack && hit_q |-> lat_q == 5'h01)
    else $error("buffer hit latency wrong");
  a_miss_lat: assert property (rd_ack && !hit_q |-> lat_q == {1'b0, ws_q} + 5'h03)
    else $error("buffer miss latency wrong");
  a_irq_masked: assert property (irq_o |-> $past(en_q) != 3'h0)
    else $error("interrupt raised while all sources masked");

  c_hit: cover property (rd_ack && hit_q);
  c_miss: cover property (rd_ack && !hit_q);
  c_irq: cover property ($rose(irq_o));
endmodule

bind foc_ctrl foc_ctrl_properties u_props (
  .clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o), .rd_req(rd_req),
  .rd_hit(rd_hit), .rd_ack(rd_ack));

// ---- test/foc_ctrl_test.sv ----
// self-checking bench for the flash operation control block
`timescale 1ns/1ns
module foc_ctrl_test;
  localparam int CK = foc_pkg::CLK_NS;
  localparam int PSUS_MAX = 11500 / CK + 4;
  localparam int ESUS_MAX = 20800 / CK + 4;
  localparam int AI_MAX = 80 / CK + 15;
  localparam int MR_MIN = 10360 / CK + 4;
  localparam int MR_MAX = 20420 / CK + 4;
  localparam int RCV_MIN = 16000 / CK + 7;
  localparam int RCV_MAX = 45000 / CK + 7;
  localparam logic [31:0] WS_TAB [3] = '{32'h00, 32'h12, 32'h13};
  localparam int LAT_TAB [3] = '{3, 5, 6};

  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic        irq;
  logic        rd_req = 1'b0;
  logic        rd_hit = 1'b0;
  logic        rd_ack;
  int          error_cnt = 0;
  int          checks = 0;
  int          cyc_n = 0;
  int          t_wr = 0;
  int          n;
  logic [31:0] q;

  always #(CK / 2) clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc_n <= cyc_n + 1;

  foc_ctrl #(.PGM_CYC(16'h07D0), .ERS_CYC(16'h0BB8), .CHK_CYC(16'h05DC)) u_dut (
    .clk_sys(clk_sys), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .irq_o(irq), .rd_req(rd_req), .rd_hit(rd_hit), .rd_ack(rd_ack));

  ////////////////////////////////////////////////////////////////////////////
  task end_sim;
    if (error_cnt == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task tmo(input int k, input int lim);
    if (k >= lim) begin
      error_cnt++;
      $display("[ERR] %0t wait timed out", $time);
      end_sim;
    end
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task rng(input int v, input int lo, input int hi);
    checks++;
    if (v < lo || v > hi) begin
      error_cnt++;
      $display("[ERR] %0t delay %0d outside %0d..%0d", $time, v, lo, hi);
    end
  endtask

  // one classic wishbone cycle, read data left in q
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_sys);
      k++;
    end while (ack !== 1'b1 && k < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    tmo(k, 20);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
    t_wr = cyc_n;
  endtask

  // reads until bit b equals v; n = cycles since the last write
  task poll(input logic [7:0] a, input int b, input logic v);
    int k;
    k = 0;
    do begin
      xfer(1'b0, a, 32'h0);
      k++;
    end while (q[b] !== v && k < 1000);
    n = cyc_n - t_wr;
    tmo(k, 1000);
  endtask

  task rd_op(input logic hit);
    int k;
    k = 0;
    @(posedge clk_sys);
    rd_req <= 1'b1;
    rd_hit <= hit;
    do begin
      @(posedge clk_sys);
      k++;
    end while (rd_ack !== 1'b1 && k < 40);
    rd_req <= 1'b0;
    n = k - 1;
    tmo(k, 40);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task t_reset;
    xfer(1'b0, foc_pkg::OFS_MCR, 32'h0);
    chk(q & 32'h300, 32'h100);
    xfer(1'b0, foc_pkg::OFS_UT0, 32'h0);
    chk(q & 32'h100, 32'h100);
    xfer(1'b0, foc_pkg::OFS_PFCR, 32'h0);
    chk(q, 32'h12);
    xfer(1'b0, foc_pkg::OFS_STS, 32'h0);
    chk(q, 32'h0);
    xfer(1'b0, 8'h1C, 32'h0);
    chk(q, 32'h0);
  endtask

  task t_opsus(input logic [31:0] run, input logic [31:0] sus, input int maxc);
    wr(foc_pkg::OFS_MCR, run);
    xfer(1'b0, foc_pkg::OFS_MCR, 32'h0);
    chk(q & 32'h100, 32'h0);
    wr(foc_pkg::OFS_MCR, run | sus);
    poll(foc_pkg::OFS_MCR, 8, 1'b1);
    rng(n, 1, maxc + 3);
    wr(foc_pkg::OFS_MCR, run);
    xfer(1'b0, foc_pkg::OFS_MCR, 32'h0);
    chk(q & 32'h100, 32'h0);
    wr(foc_pkg::OFS_MCR, run & 32'h1E);
    poll(foc_pkg::OFS_MCR, 8, 1'b1);
    rng(n, 1, ESUS_MAX + 3);
    xfer(1'b0, foc_pkg::OFS_MCR, 32'h0);
    chk(q & 32'h100, 32'h100);
  endtask

  task t_check(input logic [31:0] mode, input int lo, input int hi);
    wr(foc_pkg::OFS_UT0, mode | 32'h1);
    xfer(1'b0, foc_pkg::OFS_UT0, 32'h0);
    chk(q & 32'h100, 32'h0);
    wr(foc_pkg::OFS_UT0, mode | 32'h3);
    poll(foc_pkg::OFS_UT0, 8, 1'b1);
    rng(n, lo, hi + 3);
    wr(foc_pkg::OFS_UT0, mode | 32'h1);
    xfer(1'b0, foc_pkg::OFS_UT0, 32'h0);
    chk(q & 32'h100, 32'h0);
    wr(foc_pkg::OFS_UT0, mode);
    poll(foc_pkg::OFS_UT0, 8, 1'b1);
    rng(n, lo, hi + 3);
  endtask

  task t_brk;
    wr(foc_pkg::OFS_UT0, 32'h9);
    poll(foc_pkg::OFS_UT0, 8, 1'b1);
    wr(foc_pkg::OFS_UT0, 32'h1);
    xfer(1'b0, foc_pkg::OFS_UT0, 32'h0);
    chk(q & 32'h100, 32'h0);
    wr(foc_pkg::OFS_UT0, 32'h0);
    poll(foc_pkg::OFS_UT0, 8, 1'b1);
    rng(n, 1, AI_MAX + 3);
  endtask

  task t_lowpwr;
    wr(foc_pkg::OFS_MCR, 32'h10);
    wr(foc_pkg::OFS_MCR, 32'h0);
    xfer(1'b0, foc_pkg::OFS_MCR, 32'h0);
    chk(q & 32'h200, 32'h200);
    poll(foc_pkg::OFS_MCR, 9, 1'b0);
    rng(n, RCV_MIN, RCV_MAX + 3);
  endtask

  task t_read;
    for (int i = 0; i < 3; i++) begin
      wr(foc_pkg::OFS_PFCR, WS_TAB[i]);
      xfer(1'b0, foc_pkg::OFS_PFCR, 32'h0);
      chk(q, WS_TAB[i]);
      rd_op(1'b0);
      rng(n, LAT_TAB[i], LAT_TAB[i]);
      rd_op(1'b1);
      rng(n, 1, 1);
    end
  endtask

  task irq_is(input logic [31:0] d, input logic [7:0] a, input logic v);
    wr(a, d);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, irq}, {31'h0, v});
  endtask

  task t_irq;
    xfer(1'b0, foc_pkg::OFS_STS, 32'h0);
    chk(q, 32'h7);
    irq_is(32'h4, foc_pkg::OFS_EN, 1'b1);
    irq_is(32'h0, foc_pkg::OFS_EN, 1'b0);
    irq_is(32'h4, foc_pkg::OFS_EN, 1'b1);
    irq_is(32'h7, foc_pkg::OFS_CLR, 1'b0);
    xfer(1'b0, foc_pkg::OFS_STS, 32'h0);
    chk(q, 32'h0);
  endtask

  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset;
    t_opsus(32'h1, 32'h2, PSUS_MAX);
    t_opsus(32'h9, 32'h4, ESUS_MAX);
    t_check(32'h0, 1, AI_MAX);
    t_check(32'h4, MR_MIN, MR_MAX);
    t_brk;
    t_lowpwr;
    t_read;
    t_irq;
    end_sim;
  end
endmodule
